// ---- hw/pcs_pkg.sv ----
// Constants shared by the phase compensation and power sign register bank.
// Assumes a 16-bit register port with addresses taken as printed word offsets.
package pcs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] PCS_ADDR_COMP_A   = 16'he614;
    localparam logic [15:0] PCS_ADDR_COMP_B   = 16'he615;
    localparam logic [15:0] PCS_ADDR_COMP_C   = 16'he616;
    localparam logic [15:0] PCS_ADDR_SIGN     = 16'he617;
    localparam logic [15:0] PCS_ADDR_IRQ_STAT = 16'he6f0;
    localparam logic [15:0] PCS_ADDR_IRQ_CLR  = 16'he6f1;
    localparam logic [15:0] PCS_ADDR_IRQ_EN   = 16'he6f2;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int          PCS_COMP_W        = 10;
    localparam logic [9:0]  PCS_COMP_RST      = 10'h000;
    localparam logic [9:0]  PCS_FOLD_LO_FIRST = 10'h180;   // 384.
    localparam logic [9:0]  PCS_FOLD_HI_FIRST = 10'h380;   // 896.
    localparam logic [9:0]  PCS_VOLT_FIRST    = 10'h200;   // 512.
    localparam logic [9:0]  PCS_FOLD_STEP     = 10'h180;   // 384.
    localparam int          PCS_SIGN_W        = 9;
    localparam logic [8:0]  PCS_SIGN_RST      = 9'h000;
    localparam int          PCS_BIT_ACT_A     = 0;
    localparam int          PCS_BIT_SUM1      = 3;
    localparam int          PCS_BIT_REACT_A   = 4;
    localparam int          PCS_BIT_SUM2      = 7;
    localparam int          PCS_BIT_SUM3      = 8;

    // ------------------------------------------------------------------
    // Quantity codes of the pulse output datapaths
    // ------------------------------------------------------------------
    localparam logic [2:0]  PCS_Q_ACT         = 3'h0;
    localparam logic [2:0]  PCS_Q_REACT       = 3'h1;
    localparam logic [2:0]  PCS_Q_APP         = 3'h2;
    localparam logic [2:0]  PCS_Q_FACT        = 3'h3;
    localparam logic [2:0]  PCS_Q_FREACT      = 3'h4;

endpackage

// ---- hw/pcs_comp_fold.sv ----
// One phase compensation value folded into its effective range.
// Assumes a raw value held by the register bank on the same clock.
`timescale 1ns/10ps
module pcs_comp_fold (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       clk_en,
    input  wire logic [9:0] raw_value,
    output logic      [9:0] eff_value_r
);

    // ------------------------------------------------------------------
    // Folding
    // ------------------------------------------------------------------
    // Maps the two unused windows onto the values 384 below them.
    function automatic logic [9:0] fold(input logic [9:0] v);
        logic [9:0] r;
        r = v;
        if (v >= pcs_pkg::PCS_FOLD_HI_FIRST) begin
            r = v - pcs_pkg::PCS_FOLD_STEP;
        end else if (v >= pcs_pkg::PCS_FOLD_LO_FIRST && v < pcs_pkg::PCS_VOLT_FIRST) begin
            r = v - pcs_pkg::PCS_FOLD_STEP;
        end
        return r;
    endfunction

    // Registers the effective value for the compensation filter.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            eff_value_r <= pcs_pkg::PCS_COMP_RST;
        end else if (clk_en) begin
            eff_value_r <= fold(raw_value);
        end
    end

endmodule

// ---- hw/pcs_sum_sign.sv ----
// Sign of the summed phase powers of one pulse output datapath.
// Assumes terms already chosen by quantity code, on the same clock.
`timescale 1ns/10ps
module pcs_sum_sign #(
    parameter int PWR_W = 24
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic              result_valid,
    input  wire logic [2:0]        phase_select,
    input  wire logic [2:0]        quantity_select,
    input  wire logic [PWR_W-1:0]  term_a,
    input  wire logic [PWR_W-1:0]  term_b,
    input  wire logic [PWR_W-1:0]  term_c,
    output logic                   sum_sign_r,
    output logic                   out_active_r
);

    logic signed [PWR_W+1:0] sum_nxt;
    logic                    code_ok;

    // Sums only the phases that the phase select enables.
    always_comb begin
        sum_nxt = '0;
        if (phase_select[0]) sum_nxt = sum_nxt + {{2{term_a[PWR_W-1]}}, term_a};
        if (phase_select[1]) sum_nxt = sum_nxt + {{2{term_b[PWR_W-1]}}, term_b};
        if (phase_select[2]) sum_nxt = sum_nxt + {{2{term_c[PWR_W-1]}}, term_c};
    end

    // Reserved quantity codes suppress the output.
    assign code_ok = (quantity_select <= pcs_pkg::PCS_Q_FREACT);

    // Refreshes the sign on each new result; a suppressed output keeps it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sum_sign_r   <= 1'b0;
            out_active_r <= 1'b0;
        end else if (clk_en) begin
            out_active_r <= code_ok;
            if (result_valid && code_ok) begin
                sum_sign_r <= sum_nxt[PWR_W+1];
            end
        end
    end

endmodule

// ---- hw/pcs_regs.sv ----
// Phase compensation and power sign register bank with its interrupt logic.
// Assumes power results, source selects and output selects from the DSP core
// on sys_clk, and a register port whose strobes are one cycle long.
`timescale 1ns/10ps
module pcs_regs #(
    parameter int PWR_W = 24
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    // Register port.
    input  wire logic [15:0]       reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // Power results, one strobe per new result.
    input  wire logic              result_valid,
    input  wire logic [PWR_W-1:0]  act_tot_a,
    input  wire logic [PWR_W-1:0]  act_tot_b,
    input  wire logic [PWR_W-1:0]  act_tot_c,
    input  wire logic [PWR_W-1:0]  act_fund_a,
    input  wire logic [PWR_W-1:0]  act_fund_b,
    input  wire logic [PWR_W-1:0]  act_fund_c,
    input  wire logic [PWR_W-1:0]  react_tot_a,
    input  wire logic [PWR_W-1:0]  react_tot_b,
    input  wire logic [PWR_W-1:0]  react_tot_c,
    input  wire logic [PWR_W-1:0]  react_fund_a,
    input  wire logic [PWR_W-1:0]  react_fund_b,
    input  wire logic [PWR_W-1:0]  react_fund_c,
    input  wire logic [PWR_W-1:0]  apparent_a,
    input  wire logic [PWR_W-1:0]  apparent_b,
    input  wire logic [PWR_W-1:0]  apparent_c,
    // Selections kept in the core's mode registers.
    input  wire logic              active_sign_source_select,
    input  wire logic              reactive_sign_source_select,
    input  wire logic [2:0]        output1_phase_select,
    input  wire logic [2:0]        output2_phase_select,
    input  wire logic [2:0]        output3_phase_select,
    input  wire logic [2:0]        output1_quantity_select,
    input  wire logic [2:0]        output2_quantity_select,
    input  wire logic [2:0]        output3_quantity_select,
    // Effective compensation values for the filters.
    output logic      [9:0]        phase_a_comp_eff,
    output logic      [9:0]        phase_b_comp_eff,
    output logic      [9:0]        phase_c_comp_eff,
    // Pulse output enables after reserved code check.
    output logic                   output1_active,
    output logic                   output2_active,
    output logic                   output3_active,
    // Level interrupt.
    output logic                   irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [9:0]              phase_a_comp_r;
    logic [9:0]              phase_b_comp_r;
    logic [9:0]              phase_c_comp_r;
    logic [2:0]              act_sign_r;
    logic [2:0]              react_sign_r;
    logic                    output1_total_sign;
    logic                    output2_total_sign;
    logic                    output3_total_sign;
    logic [8:0]              sign_word;
    logic [8:0]              sign_prev_r;
    logic                    sign_seen_r;
    logic [8:0]              irq_stat_r;
    logic [8:0]              irq_en_r;
    logic [8:0]              irq_set;
    logic [8:0]              irq_clr;
    logic [15:0]             rdata_nxt;
    logic                    wr_go;
    logic                    rd_go;
    logic [PWR_W-1:0]        o1_a;
    logic [PWR_W-1:0]        o1_b;
    logic [PWR_W-1:0]        o1_c;
    logic [PWR_W-1:0]        o2_a;
    logic [PWR_W-1:0]        o2_b;
    logic [PWR_W-1:0]        o2_c;
    logic [PWR_W-1:0]        o3_a;
    logic [PWR_W-1:0]        o3_b;
    logic [PWR_W-1:0]        o3_c;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Chooses one phase's power by quantity code; reserved codes give zero.
    function automatic logic [PWR_W-1:0] pick(
        input logic [2:0]       code,
        input logic [PWR_W-1:0] act,
        input logic [PWR_W-1:0] react,
        input logic [PWR_W-1:0] app,
        input logic [PWR_W-1:0] fact,
        input logic [PWR_W-1:0] freact
    );
        logic [PWR_W-1:0] r;
        r = '0;
        case (code)
            pcs_pkg::PCS_Q_ACT:    r = act;
            pcs_pkg::PCS_Q_REACT:  r = react;
            pcs_pkg::PCS_Q_APP:    r = app;
            pcs_pkg::PCS_Q_FACT:   r = fact;
            pcs_pkg::PCS_Q_FREACT: r = freact;
            default:               r = '0;
        endcase
        return r;
    endfunction

    // Sign bit of a total or fundamental power chosen by a source select.
    function automatic logic sign_of(
        input logic             use_fund,
        input logic [PWR_W-1:0] tot,
        input logic [PWR_W-1:0] fund
    );
        return use_fund ? fund[PWR_W-1] : tot[PWR_W-1];
    endfunction

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    // Gates the strobes with the clock enable so a frozen block sees nothing.
    assign wr_go = reg_wr && clk_en;
    assign rd_go = reg_rd && clk_en;

    // Stores the compensation registers; bits 15:10 are dropped on write.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase_a_comp_r <= pcs_pkg::PCS_COMP_RST;
            phase_b_comp_r <= pcs_pkg::PCS_COMP_RST;
            phase_c_comp_r <= pcs_pkg::PCS_COMP_RST;
        end else if (wr_go) begin
            case (reg_addr)
                pcs_pkg::PCS_ADDR_COMP_A: begin
                    phase_a_comp_r <= reg_wdata[9:0];
                end
                pcs_pkg::PCS_ADDR_COMP_B: begin
                    phase_b_comp_r <= reg_wdata[9:0];
                end
                pcs_pkg::PCS_ADDR_COMP_C: begin
                    phase_c_comp_r <= reg_wdata[9:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Stores the interrupt enable register.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_en_r <= 9'h000;
        end else if (wr_go && reg_addr == pcs_pkg::PCS_ADDR_IRQ_EN) begin
            irq_en_r <= reg_wdata[8:0];
        end
    end

    // ------------------------------------------------------------------
    // Compensation folding
    // ------------------------------------------------------------------
    // Each phase gets its effective value through its own folding stage.
    pcs_comp_fold u_fold_a (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .clk_en      (clk_en),
        .raw_value   (phase_a_comp_r),
        .eff_value_r (phase_a_comp_eff)
    );

    pcs_comp_fold u_fold_b (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .clk_en      (clk_en),
        .raw_value   (phase_b_comp_r),
        .eff_value_r (phase_b_comp_eff)
    );

    pcs_comp_fold u_fold_c (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .clk_en      (clk_en),
        .raw_value   (phase_c_comp_r),
        .eff_value_r (phase_c_comp_eff)
    );

    // ------------------------------------------------------------------
    // Per-phase sign flags
    // ------------------------------------------------------------------
    // Refreshes the six phase flags on every new power result.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            act_sign_r   <= 3'h0;
            react_sign_r <= 3'h0;
        end else if (clk_en && result_valid) begin
            act_sign_r[0]   <= sign_of(active_sign_source_select, act_tot_a, act_fund_a);
            act_sign_r[1]   <= sign_of(active_sign_source_select, act_tot_b, act_fund_b);
            act_sign_r[2]   <= sign_of(active_sign_source_select, act_tot_c, act_fund_c);
            react_sign_r[0] <= sign_of(reactive_sign_source_select, react_tot_a, react_fund_a);
            react_sign_r[1] <= sign_of(reactive_sign_source_select, react_tot_b, react_fund_b);
            react_sign_r[2] <= sign_of(reactive_sign_source_select, react_tot_c, react_fund_c);
        end
    end
    // The six flags above follow the chosen total or fundamental power.

    // ------------------------------------------------------------------
    // Pulse output datapath sums
    // ------------------------------------------------------------------
    // Chooses each phase's term of each datapath by its quantity code.
    assign o1_a = pick(output1_quantity_select, act_tot_a, react_tot_a, apparent_a,
                       act_fund_a, react_fund_a);
    assign o1_b = pick(output1_quantity_select, act_tot_b, react_tot_b, apparent_b,
                       act_fund_b, react_fund_b);
    assign o1_c = pick(output1_quantity_select, act_tot_c, react_tot_c, apparent_c,
                       act_fund_c, react_fund_c);
    assign o2_a = pick(output2_quantity_select, act_tot_a, react_tot_a, apparent_a,
                       act_fund_a, react_fund_a);
    assign o2_b = pick(output2_quantity_select, act_tot_b, react_tot_b, apparent_b,
                       act_fund_b, react_fund_b);
    assign o2_c = pick(output2_quantity_select, act_tot_c, react_tot_c, apparent_c,
                       act_fund_c, react_fund_c);
    assign o3_a = pick(output3_quantity_select, act_tot_a, react_tot_a, apparent_a,
                       act_fund_a, react_fund_a);
    assign o3_b = pick(output3_quantity_select, act_tot_b, react_tot_b, apparent_b,
                       act_fund_b, react_fund_b);
    assign o3_c = pick(output3_quantity_select, act_tot_c, react_tot_c, apparent_c,
                       act_fund_c, react_fund_c);

    // Sign of the first pulse output sum.
    pcs_sum_sign #(.PWR_W(PWR_W)) u_sum1 (
        .sys_clk         (sys_clk),
        .srst            (srst),
        .clk_en          (clk_en),
        .result_valid    (result_valid),
        .phase_select    (output1_phase_select),
        .quantity_select (output1_quantity_select),
        .term_a          (o1_a),
        .term_b          (o1_b),
        .term_c          (o1_c),
        .sum_sign_r      (output1_total_sign),
        .out_active_r    (output1_active)
    );

    // Sign of the second pulse output sum.
    pcs_sum_sign #(.PWR_W(PWR_W)) u_sum2 (
        .sys_clk         (sys_clk),
        .srst            (srst),
        .clk_en          (clk_en),
        .result_valid    (result_valid),
        .phase_select    (output2_phase_select),
        .quantity_select (output2_quantity_select),
        .term_a          (o2_a),
        .term_b          (o2_b),
        .term_c          (o2_c),
        .sum_sign_r      (output2_total_sign),
        .out_active_r    (output2_active)
    );

    // Sign of the third pulse output sum.
    pcs_sum_sign #(.PWR_W(PWR_W)) u_sum3 (
        .sys_clk         (sys_clk),
        .srst            (srst),
        .clk_en          (clk_en),
        .result_valid    (result_valid),
        .phase_select    (output3_phase_select),
        .quantity_select (output3_quantity_select),
        .term_a          (o3_a),
        .term_b          (o3_b),
        .term_c          (o3_c),
        .sum_sign_r      (output3_total_sign),
        .out_active_r    (output3_active)
    );

    // Assembles the sign word in its documented bit order.
    always_comb begin
        sign_word = pcs_pkg::PCS_SIGN_RST;
        sign_word[pcs_pkg::PCS_BIT_ACT_A +: 3]   = act_sign_r;
        sign_word[pcs_pkg::PCS_BIT_SUM1]         = output1_total_sign;
        sign_word[pcs_pkg::PCS_BIT_REACT_A +: 3] = react_sign_r;
        sign_word[pcs_pkg::PCS_BIT_SUM2]         = output2_total_sign;
        sign_word[pcs_pkg::PCS_BIT_SUM3]         = output3_total_sign;
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Remembers the last sign word so that any flag change raises an event.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sign_prev_r <= pcs_pkg::PCS_SIGN_RST;
            sign_seen_r <= 1'b0;
        end else if (clk_en) begin
            sign_prev_r <= sign_word;
            sign_seen_r <= 1'b1;
        end
    end

    assign irq_set = sign_seen_r ? (sign_word ^ sign_prev_r) : 9'h000;
    assign irq_clr = (wr_go && reg_addr == pcs_pkg::PCS_ADDR_IRQ_CLR) ? reg_wdata[8:0] : 9'h000;

    // Sticky status; a change in the clearing cycle stays set.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_stat_r <= 9'h000;
        end else if (clk_en) begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // Raises the level interrupt while an enabled status bit is set.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Selects read data; unmapped and write-only addresses read zero.
    always_comb begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            pcs_pkg::PCS_ADDR_COMP_A:   rdata_nxt = {6'h00, phase_a_comp_r};
            pcs_pkg::PCS_ADDR_COMP_B:   rdata_nxt = {6'h00, phase_b_comp_r};
            pcs_pkg::PCS_ADDR_COMP_C:   rdata_nxt = {6'h00, phase_c_comp_r};
            pcs_pkg::PCS_ADDR_SIGN:     rdata_nxt = {7'h00, sign_word};
            pcs_pkg::PCS_ADDR_IRQ_STAT: rdata_nxt = {7'h00, irq_stat_r};
            pcs_pkg::PCS_ADDR_IRQ_EN:   rdata_nxt = {7'h00, irq_en_r};
            default:                    rdata_nxt = 16'h0000;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            reg_rdata <= rd_go ? rdata_nxt : 16'h0000;
        end
    end
    // Writes to the sign address decode to nothing and are dropped.

endmodule

// ---- tb/pcs_regs_props.sv ----
// Checker of the compensation and sign register bank ports.
// Assumes it is bound to pcs_regs and that srst is synchronous, active high.
`timescale 1ns/10ps
module pcs_regs_props #(
    parameter int PWR_W = 24
) (
    input wire logic             sys_clk,
    input wire logic             srst,
    input wire logic             clk_en,
    input wire logic [15:0]      reg_addr,
    input wire logic             reg_rd,
    input wire logic [15:0]      reg_rdata,
    input wire logic             result_valid,
    input wire logic [PWR_W-1:0] act_tot_a,
    input wire logic [PWR_W-1:0] react_tot_a,
    input wire logic             active_sign_source_select,
    input wire logic             reactive_sign_source_select,
    input wire logic [2:0]       output1_phase_select,
    input wire logic [2:0]       output1_quantity_select,
    input wire logic [9:0]       phase_a_comp_eff,
    input wire logic [9:0]       phase_b_comp_eff,
    input wire logic [9:0]       phase_c_comp_eff,
    input wire logic             output1_active
);
    // Every check runs on the one clock and is quiet during reset.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_sign_hi_zero: assert property (
        clk_en && reg_rd && reg_addr == 16'he617 |=> reg_rdata[15:9] == 7'h00)
        else $error("sign word upper bits set");
    a_comp_hi_zero: assert property (
        clk_en && reg_rd && reg_addr inside {16'he614, 16'he615, 16'he616}
        |=> reg_rdata[15:10] == 6'h00) else $error("compensation upper bits set");
    a_fold_a: assert property (phase_a_comp_eff[8:7] != 2'h3)
        else $error("phase A value not folded");
    a_fold_bc: assert property (
        phase_b_comp_eff[8:7] != 2'h3 && phase_c_comp_eff[8:7] != 2'h3)
        else $error("phase B or C value not folded");
    a_out_active: assert property (
        !$past(srst) && $past(clk_en)
        |-> output1_active == ($past(output1_quantity_select) <= 3'h4))
        else $error("output 1 enable wrong for its code");
    a_act_sign: assert property (
        clk_en && result_valid && !active_sign_source_select ##1 clk_en && reg_rd
        && reg_addr == 16'he617 |=> reg_rdata[0] == $past(act_tot_a[PWR_W-1], 2))
        else $error("phase A active sign wrong");
    a_react_sign: assert property (
        clk_en && result_valid && !reactive_sign_source_select ##1 clk_en && reg_rd
        && reg_addr == 16'he617 |=> reg_rdata[4] == $past(react_tot_a[PWR_W-1], 2))
        else $error("phase A reactive sign wrong");
    a_sum1_sign: assert property (
        clk_en && result_valid && output1_phase_select == 3'h1
        && output1_quantity_select == 3'h0 ##1 clk_en && reg_rd && reg_addr == 16'he617
        |=> reg_rdata[3] == $past(act_tot_a[PWR_W-1], 2)) else $error("output 1 sign wrong");
endmodule
bind pcs_regs pcs_regs_props #(.PWR_W(PWR_W)) pcs_regs_props_i (.*);

// ---- tb/pcs_regs_bench.sv ----
// Self-checking bench of the compensation and sign register bank.
// Assumes the design top pcs_regs with its checker bound beside it.
`timescale 1ns/10ps
module pcs_regs_bench;
    logic        sys_clk, srst, clk_en, reg_wr, reg_rd, result_valid, irq;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [23:0] act_tot_a, act_tot_b, act_tot_c, act_fund_a, act_fund_b, act_fund_c;
    logic [23:0] react_tot_a, react_tot_b, react_tot_c, react_fund_a, react_fund_b, react_fund_c;
    logic [23:0] apparent_a, apparent_b, apparent_c;
    logic        active_sign_source_select, reactive_sign_source_select;
    logic [2:0]  output1_phase_select, output2_phase_select, output3_phase_select;
    logic [2:0]  output1_quantity_select, output2_quantity_select, output3_quantity_select;
    logic [9:0]  phase_a_comp_eff, phase_b_comp_eff, phase_c_comp_eff;
    logic        output1_active, output2_active, output3_active;
    int          n_mismatch, tests_run, cyc = 0;
    // Each row holds a written word and the effective value it must give.
    logic [25:0] rows [7] = '{{16'h0190, 10'h010}, {16'h01ff, 10'h07f}, {16'h0180, 10'h000},
        {16'hfd7f, 10'h17f}, {16'h0380, 10'h200}, {16'h03ff, 10'h27f}, {16'h037f, 10'h37f}};
    pcs_regs pcs_regs_i (.*);
    // The clock toggles every 10 ns, half of its 20 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // A hang is cut short after far more cycles than the tests need.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    // A read strobe of one cycle; the data stand only in the next cycle.
    task automatic rc(input logic [15:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
        @(posedge sys_clk);
    endtask
    task automatic pw();
        result_valid <= 1'b1;
        @(posedge sys_clk);
        result_valid <= 1'b0;
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence: reset, table of compensation words, then sign cases.
    initial begin
        {reg_wr, reg_rd, result_valid, reg_addr, reg_wdata, n_mismatch, tests_run} = '0;
        {active_sign_source_select, reactive_sign_source_select, clk_en, srst} = 4'h3;
        {act_tot_a, act_tot_b, act_tot_c, act_fund_a, act_fund_b, act_fund_c} = '0;
        {react_tot_a, react_tot_b, react_tot_c, react_fund_a, react_fund_b, react_fund_c} = '0;
        {apparent_a, apparent_b, apparent_c} = '0;
        {output1_phase_select, output2_phase_select, output3_phase_select} = '0;
        {output1_quantity_select, output2_quantity_select, output3_quantity_select} = '0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) rc(16'he614 + 16'(i), 16'h0000);
        rc(16'h1234, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            wr(16'he614 + 16'(i % 3), rows[i][25:10]);
            rc(16'he614 + 16'(i % 3), rows[i][25:10] & 16'h03ff);
            chk("comp_eff", {6'h0, rows[i][9:0]}, {6'h0, i % 3 == 0 ? phase_a_comp_eff :
                i % 3 == 1 ? phase_b_comp_eff : phase_c_comp_eff});
        end
        {act_tot_a, act_tot_b, act_tot_c} <= {24'hfffffd, 24'h000001, 24'hfffffd};
        {react_tot_b, react_tot_c, react_fund_a, act_fund_b} <= '1;
        {output1_phase_select, output2_phase_select, output3_phase_select} <= 9'h077;
        output2_quantity_select <= 3'h1;
        @(posedge sys_clk);
        pw();
        rc(16'he617, 16'h01ed);
        chk("irq", 16'h0000, {15'h0, irq});
        rc(16'he6f0, 16'h01ed);
        wr(16'he6f2, 16'h0001);
        repeat (2) @(posedge sys_clk);
        chk("irq", 16'h0001, {15'h0, irq});
        wr(16'he6f1, 16'h01ff);
        repeat (2) @(posedge sys_clk);
        chk("irq", 16'h0000, {15'h0, irq});
        {active_sign_source_select, reactive_sign_source_select} <= 2'h3;
        {output1_quantity_select, output2_quantity_select, output3_quantity_select} <= 9'h0e5;
        output2_phase_select <= 3'h1;
        @(posedge sys_clk);
        pw();
        rc(16'he617, 16'h0192);
        chk("output3_active", 16'h0000, {15'h0, output3_active});
        chk("output2_active", 16'h0001, {15'h0, output2_active});
        wr(16'he617, 16'hffff);
        rc(16'he617, 16'h0192);
        // A write while the clock enable is low must leave phase A unchanged.
        clk_en <= 1'b0;
        wr(16'he614, 16'h0155);
        clk_en <= 1'b1;
        rc(16'he614, 16'h037f);
        for (int i = 0; i < 8; i++) begin
            output1_quantity_select <= 3'(i);
            @(posedge sys_clk);
        end
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rc(16'he617, 16'h0000);
        finish_test();
    end
endmodule
